// [pkg/bus_matching_port_adapter_regs.vh]
// Purpose: register map, field positions and counts of the port adapter
// Assumes: APB, 32-bit data, one word per register
// Notes: definitions only
`ifndef BUS_MATCHING_PORT_ADAPTER_REGS_VH
`define BUS_MATCHING_PORT_ADAPTER_REGS_VH

// Register byte addresses
`define REG_CTRL_ADDR 8'h00
`define REG_STATUS_ADDR 8'h04
`define REG_OFS_A2B_AF_ADDR 8'h08
`define REG_OFS_A2B_AE_ADDR 8'h0C
`define REG_OFS_C2A_AF_ADDR 8'h10
`define REG_OFS_C2A_AE_ADDR 8'h14

// Control fields and reset value
`define CTRL_PROG_EN_BIT 0
`define CTRL_SERIAL_BIT 1
`define CTRL_W 2
`define CTRL_RESET 2'h0

// Status fields
`define ST_BIG_ENDIAN_BIT 0
`define ST_FALL_THROUGH_BIT 1
`define ST_TX_BYTE_BIT 2
`define ST_RX_BYTE_BIT 3
`define ST_PROG_DONE_BIT 4
`define ST_HOST_FULL_N_BIT 5
`define ST_RX_FULL_N_BIT 6
`define ST_TX_EMPTY_N_BIT 7
`define ST_TX_CNT_LSB 8
`define ST_RX_CNT_LSB 10

// Offset preset loaded by master reset
`define OFS_PRESET 8

// Cycles from reset release to output flag low
`define FLAG_DLY_STD 2'h2
`define FLAG_DLY_FALL_THROUGH_MODE 2'h1

// Piece indices
`define LAST_BYTE 2'h3
`define LAST_WORD 2'h1
`define LAST_PARALLEL 2'h3

// Synchroniser lanes
`define SY_N 10
`define SY_MRA 0
`define SY_MRC 1
`define SY_PRA 2
`define SY_PRC 3
`define SY_BE 4
`define SY_FT 5
`define SY_TXW 6
`define SY_RXW 7
`define SY_SD 8
`define SY_SEN 9

`endif

// [logic/bus_matching_port_adapter.v]
// Purpose: width matching between 36-bit FIFO words and 18/9-bit ports
// Assumes: one clock MCLK, FIFO arrays outside, port logic on MCLK
// Notes: configuration and reset pins are synchronised here
//
// The address map and register access over APB were decided locally.
`default_nettype none
`include "bus_matching_port_adapter_regs.vh"

module bus_matching_port_adapter #(
    parameter OFFSET_W = 11
) (
    input wire MCLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire FIFO_A2B_MASTER_RESET_N,
    input wire FIFO_C2A_MASTER_RESET_N,
    input wire FIFO_A2B_PARTIAL_RESET_N,
    input wire FIFO_C2A_PARTIAL_RESET_N,
    input wire BIG_ENDIAN_SEL,
    input wire FALL_THROUGH_MODE,
    input wire TX_PORT_WIDTH_SEL,
    input wire RX_PORT_WIDTH_SEL,
    input wire SERIAL_OFFSET_IN,
    input wire SERIAL_OFFSET_EN,
    input wire HOST_CHIP_SEL_N,
    input wire HOST_WRITE,
    input wire HOST_MAIL_SEL,
    input wire [35:0] HOST_DATA,
    output wire HOST_FULL_N,
    input wire A2B_WREADY,
    output reg A2B_WE,
    output reg [35:0] A2B_WDATA,
    input wire A2B_RVALID,
    input wire [35:0] A2B_RDATA,
    output wire A2B_RREQ,
    input wire TX_READ,
    output reg [17:0] TX_DATA,
    output reg TX_EMPTY_N,
    input wire RX_WRITE,
    input wire RX_MAIL_SEL,
    input wire [17:0] RX_DATA,
    output wire RX_FULL_N,
    input wire C2A_READY,
    output reg C2A_WE,
    output reg [35:0] C2A_WDATA
);

    localparam OW4 = 4 * OFFSET_W;
    localparam [31:0] SER_LAST_W = OW4 - 1;
    localparam [5:0] SER_LAST = SER_LAST_W[5:0];
    localparam [31:0] PRESET_W = `OFS_PRESET;
    localparam [OFFSET_W-1:0] PRESET = PRESET_W[OFFSET_W-1:0];

    // Piece of a long word for the given read index
    function [17:0] pick;
        input [35:0] w;
        input [1:0] i;
        input byt;
        input big;
        reg [1:0] l;
        reg wl;
        begin
            l = big ? ~i : i;
            wl = i[0] ^ big;
            if (byt)
                pick = {9'h000, w[l*9 +: 9]};
            else
                pick = w[wl*18 +: 18];
        end
    endfunction

    // Long word with one piece dropped into its lane
    function [35:0] place;
        input [35:0] w;
        input [17:0] p;
        input [1:0] i;
        input byt;
        input big;
        reg [1:0] l;
        reg wl;
        begin
            l = big ? ~i : i;
            wl = i[0] ^ big;
            place = w;
            if (byt)
                place[l*9 +: 9] = p[8:0];
            else
                place[wl*18 +: 18] = p;
        end
    endfunction

    // Two-flop synchronisers for all configuration and reset pin inputs
    wire [`SY_N-1:0] pins;
    reg [`SY_N-1:0] sy1_q;
    reg [`SY_N-1:0] sy2_q;
    reg mra_prev_q;
    assign pins = {SERIAL_OFFSET_EN, SERIAL_OFFSET_IN, RX_PORT_WIDTH_SEL,
        TX_PORT_WIDTH_SEL, FALL_THROUGH_MODE, BIG_ENDIAN_SEL,
        FIFO_C2A_PARTIAL_RESET_N, FIFO_A2B_PARTIAL_RESET_N,
        FIFO_C2A_MASTER_RESET_N, FIFO_A2B_MASTER_RESET_N};
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            sy1_q <= {`SY_N{1'b0}};
            sy2_q <= {`SY_N{1'b0}};
            mra_prev_q <= 1'b0;
        end
        else
        begin
            sy1_q <= pins;
            sy2_q <= sy1_q;
            mra_prev_q <= sy2_q[`SY_MRA];
        end
    end

    // Per-FIFO reset terms; partial keeps configuration
    wire mra_act = ~sy2_q[`SY_MRA];
    wire mrc_act = ~sy2_q[`SY_MRC];
    wire a2b_rst = RST | mra_act | ~sy2_q[`SY_PRA];
    wire c2a_rst = RST | mrc_act | ~sy2_q[`SY_PRC];
    wire mra_rise = sy2_q[`SY_MRA] & ~mra_prev_q;

    // APB control register
    reg [`CTRL_W-1:0] ctrl_q;
    wire apb_wr = PSEL & PENABLE & PWRITE;
    always @(posedge MCLK)
    begin
        if (RST)
            ctrl_q <= `CTRL_RESET;
        else if (apb_wr && PADDR == `REG_CTRL_ADDR)
            ctrl_q <= PWDATA[`CTRL_W-1:0];
    end

    // Configuration caught at A2B master reset release
    reg be_q;
    reg ft_q;
    reg txb_q;
    reg rxb_q;
    reg prog_need_q;
    reg prog_ser_q;
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            be_q <= 1'b0;
            ft_q <= 1'b0;
            txb_q <= 1'b0;
            rxb_q <= 1'b0;
            prog_need_q <= 1'b0;
            prog_ser_q <= 1'b0;
        end
        else if (mra_rise)
        begin
            be_q <= sy2_q[`SY_BE];
            ft_q <= sy2_q[`SY_FT];
            txb_q <= sy2_q[`SY_TXW];
            rxb_q <= sy2_q[`SY_RXW];
            prog_need_q <= ctrl_q[`CTRL_PROG_EN_BIT];
            prog_ser_q <= ctrl_q[`CTRL_SERIAL_BIT];
        end
    end

    // Offset storage, first shifted value in the top slot
    reg [OW4-1:0] ofs_q;
    reg [5:0] sbit_q;
    reg [1:0] pidx_q;
    reg done_q;
    wire host_wr = ~HOST_CHIP_SEL_N & HOST_WRITE & ~HOST_MAIL_SEL;
    // Latch cycle excluded: mode bits are still the old ones then
    wire prog_act = prog_need_q & ~done_q & ~a2b_rst & ~c2a_rst & ~mra_rise;
    // Slot index kept 2 bits wide before it is scaled
    wire [1:0] pslot = ~pidx_q;
    wire ser_bit = prog_act & prog_ser_q & sy2_q[`SY_SEN];
    wire par_wr = prog_act & ~prog_ser_q & host_wr;
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            ofs_q <= {4{PRESET}};
            sbit_q <= 6'h00;
            pidx_q <= 2'h0;
            done_q <= 1'b0;
        end
        else if (mra_act | mrc_act)
        begin
            sbit_q <= 6'h00;
            pidx_q <= 2'h0;
            done_q <= 1'b0;
            if (mra_act)
                ofs_q[OW4-1 -: 2*OFFSET_W] <= {PRESET, PRESET};
            if (mrc_act)
                ofs_q[2*OFFSET_W-1:0] <= {PRESET, PRESET};
        end
        else if (ser_bit)
        begin
            ofs_q <= {ofs_q[OW4-2:0], sy2_q[`SY_SD]};
            sbit_q <= sbit_q + 6'h01;
            if (sbit_q == SER_LAST)
                done_q <= 1'b1;
        end
        else if (par_wr)
        begin
            ofs_q[pslot*OFFSET_W +: OFFSET_W] <= HOST_DATA[OFFSET_W-1:0];
            pidx_q <= pidx_q + 2'h1;
            if (pidx_q == `LAST_PARALLEL)
                done_q <= 1'b1;
        end
    end

    // Input-side ready flags, registered after programming
    reg host_full_q;
    reg rx_full_q;
    // No false flag rise while the new mode is being latched
    wire cfg_ok = (~prog_need_q | done_q) & ~mra_rise;
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            host_full_q <= 1'b0;
            rx_full_q <= 1'b0;
        end
        else
        begin
            host_full_q <= ~a2b_rst & cfg_ok;
            rx_full_q <= ~c2a_rst & cfg_ok;
        end
    end
    wire fifo_ok = host_full_q & rx_full_q;
    assign HOST_FULL_N = host_full_q & A2B_WREADY;
    assign RX_FULL_N = rx_full_q & C2A_READY;

    // Host writes into the first FIFO array
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            A2B_WE <= 1'b0;
            A2B_WDATA <= 36'h000000000;
        end
        else
        begin
            A2B_WE <= host_wr & fifo_ok & A2B_WREADY & ~a2b_rst;
            if (host_wr)
                A2B_WDATA <= HOST_DATA;
        end
    end

    // Transmit disassembly state
    reg [35:0] thold_q;
    reg [35:0] thold_d;
    reg [1:0] tcnt_q;
    reg [1:0] tcnt_d;
    reg tval_q;
    reg tval_d;
    reg [1:0] tdly_q;
    wire tlast = tcnt_q == (txb_q ? `LAST_BYTE : `LAST_WORD);
    wire tx_adv = TX_READ & TX_EMPTY_N & tval_q;
    // fetch only when whole word is used up
    assign A2B_RREQ = ~a2b_rst & A2B_RVALID & (~tval_q | (tx_adv & tlast));
    always @*
    begin
        thold_d = thold_q;
        tcnt_d = tcnt_q;
        tval_d = tval_q;
        if (a2b_rst)
        begin
            thold_d = 36'h000000000;
            tcnt_d = 2'h0;
            tval_d = 1'b0;
        end
        else if (A2B_RREQ)
        begin
            thold_d = A2B_RDATA;
            tcnt_d = 2'h0;
            tval_d = 1'b1;
        end
        else if (tx_adv)
        begin
            tcnt_d = tlast ? 2'h0 : tcnt_q + 2'h1;
            tval_d = ~tlast;
        end
    end

    // Transmit registers; piece chosen from next state
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            thold_q <= 36'h000000000;
            tcnt_q <= 2'h0;
            tval_q <= 1'b0;
            TX_DATA <= 18'h00000;
        end
        else
        begin
            thold_q <= thold_d;
            tcnt_q <= tcnt_d;
            tval_q <= tval_d;
            TX_DATA <= pick(thold_d, tcnt_d, txb_q, be_q);
        end
    end

    // Empty flag holds until delay after reset runs out
    wire ft_sel = mra_act ? sy2_q[`SY_FT] : ft_q;
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            tdly_q <= 2'h0;
            TX_EMPTY_N <= 1'b0;
        end
        else if (a2b_rst)
            tdly_q <= ft_sel ? `FLAG_DLY_FALL_THROUGH_MODE : `FLAG_DLY_STD;
        else if (tdly_q != 2'h0)
        begin
            tdly_q <= tdly_q - 2'h1;
            if (tdly_q == 2'h1)
                TX_EMPTY_N <= 1'b0;
        end
        else
            TX_EMPTY_N <= tval_d;
    end

    // Receive assembly state
    reg [35:0] racc_q;
    reg [1:0] rcnt_q;
    wire rlast = rcnt_q == (rxb_q ? `LAST_BYTE : `LAST_WORD);
    wire rx_acc = RX_WRITE & ~RX_MAIL_SEL & RX_FULL_N & fifo_ok & ~c2a_rst;
    wire [35:0] racc_nx = place(racc_q, RX_DATA, rcnt_q, rxb_q, be_q);
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            racc_q <= 36'h000000000;
            rcnt_q <= 2'h0;
            C2A_WE <= 1'b0;
            C2A_WDATA <= 36'h000000000;
        end
        else if (c2a_rst)
        begin
            racc_q <= 36'h000000000;
            rcnt_q <= 2'h0;
            C2A_WE <= 1'b0;
        end
        else
        begin
            C2A_WE <= 1'b0;
            if (rx_acc)
            begin
                racc_q <= racc_nx;
                rcnt_q <= rlast ? 2'h0 : rcnt_q + 2'h1;
                if (rlast)
                begin
                    C2A_WE <= 1'b1;
                    C2A_WDATA <= racc_nx;
                end
            end
        end
    end

    // Read mux; status shows latched mode and counters
    wire [31:0] status;
    reg [31:0] rd_mux;
    reg mapped;
    assign status = {20'h00000, rcnt_q, tcnt_q, TX_EMPTY_N, rx_full_q,
        host_full_q, done_q, rxb_q, txb_q, ft_q, be_q};
    always @*
    begin
        mapped = 1'b1;
        rd_mux = 32'h00000000;
        case (PADDR)
            `REG_CTRL_ADDR: rd_mux[`CTRL_W-1:0] = ctrl_q;
            `REG_STATUS_ADDR: rd_mux = status;
            `REG_OFS_A2B_AF_ADDR:
                rd_mux[OFFSET_W-1:0] = ofs_q[OW4-1 -: OFFSET_W];
            `REG_OFS_A2B_AE_ADDR:
                rd_mux[OFFSET_W-1:0] = ofs_q[3*OFFSET_W-1 -: OFFSET_W];
            `REG_OFS_C2A_AF_ADDR:
                rd_mux[OFFSET_W-1:0] = ofs_q[2*OFFSET_W-1 -: OFFSET_W];
            `REG_OFS_C2A_AE_ADDR:
                rd_mux[OFFSET_W-1:0] = ofs_q[OFFSET_W-1:0];
            default: mapped = 1'b0;
        endcase
    end

    // Read data captured in setup phase, stable in access
    always @(posedge MCLK)
    begin
        if (RST)
            PRDATA <= 32'h00000000;
        else if (PSEL & ~PENABLE)
            PRDATA <= rd_mux;
    end
    // Zero wait states; unmapped access flagged
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;

endmodule // bus_matching_port_adapter
`default_nettype wire

// [testbench/bmpa_props.sv]
// Purpose: port checker for the width adapter
// Assumes: one clock, config pins static between resets
// Notes: quiet count masks synchroniser lag after any reset
`default_nettype none
module bmpa_props (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic FIFO_A2B_MASTER_RESET_N,
    input wire logic FIFO_C2A_MASTER_RESET_N,
    input wire logic FIFO_A2B_PARTIAL_RESET_N,
    input wire logic FIFO_C2A_PARTIAL_RESET_N,
    input wire logic BIG_ENDIAN_SEL,
    input wire logic TX_PORT_WIDTH_SEL,
    input wire logic RX_PORT_WIDTH_SEL,
    input wire logic HOST_CHIP_SEL_N,
    input wire logic HOST_WRITE,
    input wire logic HOST_MAIL_SEL,
    input wire logic [35:0] HOST_DATA,
    input wire logic HOST_FULL_N,
    input wire logic A2B_WE,
    input wire logic [35:0] A2B_WDATA,
    input wire logic A2B_RVALID,
    input wire logic [35:0] A2B_RDATA,
    input wire logic A2B_RREQ,
    input wire logic TX_READ,
    input wire logic [17:0] TX_DATA,
    input wire logic TX_EMPTY_N,
    input wire logic RX_WRITE,
    input wire logic RX_MAIL_SEL,
    input wire logic RX_FULL_N,
    input wire logic C2A_WE
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] quiet_q;
    logic quiet, host_q, rx_q;
    logic [35:0] hd_q, rd_q;
    assign quiet = quiet_q == 4'hF;
    // Internal resets lag the pins, so wait well past them
    always_ff @(posedge MCLK)
    begin
        if (RST || !(FIFO_A2B_MASTER_RESET_N && FIFO_C2A_MASTER_RESET_N
            && FIFO_A2B_PARTIAL_RESET_N && FIFO_C2A_PARTIAL_RESET_N))
            quiet_q <= 4'h0;
        else if (!quiet)
            quiet_q <= quiet_q + 4'h1;
    end
    // Takes delayed to line up with registered outputs
    always_ff @(posedge MCLK)
    begin
        host_q <= !HOST_CHIP_SEL_N && HOST_WRITE && !HOST_MAIL_SEL
            && HOST_FULL_N;
        hd_q <= HOST_DATA;
        rd_q <= A2B_RDATA;
        rx_q <= RX_WRITE && !RX_MAIL_SEL && RX_FULL_N;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_fetch;
        A2B_RREQ && quiet;
    endsequence
    property p_fetch_valid;
        A2B_RREQ |-> A2B_RVALID;
    endproperty
    a_fetch_valid: assert property (p_fetch_valid)
        else $error("fetch from empty array");
    property p_fetch_need;
        s_fetch |-> !TX_EMPTY_N || TX_READ;
    endproperty
    a_fetch_need: assert property (p_fetch_need)
        else $error("fetch while piece held");
    property p_fetch_show;
        s_fetch |=> TX_EMPTY_N && (TX_PORT_WIDTH_SEL ?
            TX_DATA[8:0] == (BIG_ENDIAN_SEL ? rd_q[35:27] : rd_q[8:0]) :
            TX_DATA == (BIG_ENDIAN_SEL ? rd_q[35:18] : rd_q[17:0]));
    endproperty
    a_fetch_show: assert property (p_fetch_show)
        else $error("wrong first piece");
    property p_tx_hold;
        quiet && TX_EMPTY_N && !TX_READ |=> $stable(TX_DATA) && TX_EMPTY_N;
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("piece changed without read");
    property p_rx_commit;
        C2A_WE |-> rx_q;
    endproperty
    a_rx_commit: assert property (p_rx_commit)
        else $error("commit without write");
    property p_rx_word_gap;
        C2A_WE && !RX_PORT_WIDTH_SEL |=> !C2A_WE;
    endproperty
    a_rx_word_gap: assert property (p_rx_word_gap)
        else $error("word commit too soon");
    property p_rx_byte_gap;
        C2A_WE && RX_PORT_WIDTH_SEL |=> (!C2A_WE) [*3];
    endproperty
    a_rx_byte_gap: assert property (p_rx_byte_gap)
        else $error("byte commit too soon");
    property p_host_write;
        A2B_WE |-> host_q && A2B_WDATA == hd_q;
    endproperty
    a_host_write: assert property (p_host_write)
        else $error("array write not taken from host");
endmodule // bmpa_props
`default_nettype wire

// [testbench/fifo_arrays.sv]
// Purpose: model of the two 36-bit arrays beside the adapter
// Assumes: first array four deep, second captured in a queue
// Notes: empty first array shows inverted stale data
`default_nettype none
module fifo_arrays (
    input wire logic MCLK,
    input wire logic A2B_WE,
    input wire logic [35:0] A2B_WDATA,
    output logic A2B_WREADY,
    output logic A2B_RVALID,
    output logic [35:0] A2B_RDATA,
    input wire logic A2B_RREQ,
    input wire logic stall,
    output logic C2A_READY,
    input wire logic C2A_WE,
    input wire logic [35:0] C2A_WDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [35:0] mem [0:3];
    logic [35:0] last = 36'h0;
    logic [35:0] got [$];
    logic [1:0] wp = 2'h0, rp = 2'h0;
    logic [2:0] n = 3'h0;
    // Stale data inverted so a late read cannot pass
    assign A2B_WREADY = n != 3'h4;
    assign A2B_RVALID = n != 3'h0;
    assign A2B_RDATA = A2B_RVALID ? mem[rp] : ~last;
    assign C2A_READY = !stall;
    // Array pointers and capture of committed words
    always @(posedge MCLK)
    begin
        if (A2B_WE)
        begin
            mem[wp] <= A2B_WDATA;
            wp <= wp + 2'h1;
        end
        if (A2B_RREQ)
        begin
            last <= mem[rp];
            rp <= rp + 2'h1;
        end
        n <= n + {2'h0, A2B_WE} - {2'h0, A2B_RREQ};
        if (C2A_WE)
            got.push_back(C2A_WDATA);
    end
endmodule // fifo_arrays
`default_nettype wire

// [testbench/bus_matching_port_adapter_tb.sv]
// Purpose: self-checking bench for the width adapter
// Assumes: APB master tasks, partner arrays model
// Notes: offsets shortened to five bits
`default_nettype none
module bus_matching_port_adapter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK = 1'h0, RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0;
    logic PWRITE = 1'h0, PREADY, PSLVERR, er, stall = 1'h0;
    logic [7:0] PADDR = 8'h0;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic FIFO_A2B_MASTER_RESET_N = 1'h1, FIFO_C2A_MASTER_RESET_N = 1'h1;
    logic FIFO_A2B_PARTIAL_RESET_N = 1'h1;
    logic FIFO_C2A_PARTIAL_RESET_N = 1'h1;
    logic BIG_ENDIAN_SEL = 1'h0, FALL_THROUGH_MODE = 1'h0;
    logic TX_PORT_WIDTH_SEL = 1'h0, RX_PORT_WIDTH_SEL = 1'h0;
    logic SERIAL_OFFSET_IN = 1'h0, SERIAL_OFFSET_EN = 1'h0;
    logic HOST_CHIP_SEL_N = 1'h1, HOST_WRITE = 1'h0, HOST_MAIL_SEL = 1'h0;
    logic [35:0] HOST_DATA = 36'h0, A2B_WDATA, A2B_RDATA, C2A_WDATA;
    logic HOST_FULL_N, A2B_WREADY, A2B_WE, A2B_RVALID, A2B_RREQ;
    logic TX_READ = 1'h0, TX_EMPTY_N, RX_WRITE = 1'h0, RX_MAIL_SEL = 1'h1;
    logic [17:0] TX_DATA, RX_DATA = 18'h0;
    logic RX_FULL_N, C2A_READY, C2A_WE;
    int fail_count = 0, tests_run = 0, cyc = 0;
    bus_matching_port_adapter #(.OFFSET_W(5)) bus_matching_port_adapter_i (.*);
    fifo_arrays fifo_arrays_i (.*);
    always #25 MCLK = ~MCLK;
    task automatic chk(input string s, input logic [35:0] g, e);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Cycle ceiling; partner stalls on a fixed pattern
    always @(posedge MCLK)
    begin
        cyc <= cyc + 1;
        stall <= (cyc % 3 == 0);
        if (cyc == 8000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    function automatic logic [17:0] pc(input logic [35:0] w, input int k,
        input logic b);
        return b ? {9'h0, w[9 * k +: 9]} : w[18 * k +: 18];
    endfunction
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'h1;
        @(posedge MCLK);
        while (PREADY !== 1'h1)
            @(posedge MCLK);
        r = PRDATA;
        er = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge MCLK);
    endtask
    task automatic hw(input logic [35:0] d);
        HOST_CHIP_SEL_N <= 1'h0;
        HOST_WRITE <= 1'h1;
        HOST_DATA <= d;
        @(posedge MCLK);
        while (HOST_FULL_N !== 1'h1)
            @(posedge MCLK);
        HOST_CHIP_SEL_N <= 1'h1;
        HOST_WRITE <= 1'h0;
        HOST_DATA <= ~d;
        @(posedge MCLK);
    endtask
    task automatic txr(input logic [17:0] e, input logic b);
        while (TX_EMPTY_N !== 1'h1)
            @(posedge MCLK);
        chk("tx", b ? {9'h0, TX_DATA[8:0]} : TX_DATA, e);
        TX_READ <= 1'h1;
        @(posedge MCLK);
        TX_READ <= 1'h0;
        @(posedge MCLK);
    endtask
    task automatic rxp(input logic [17:0] p);
        RX_WRITE <= 1'h1;
        RX_DATA <= p;
        @(posedge MCLK);
        while (RX_FULL_N !== 1'h1)
            @(posedge MCLK);
        RX_WRITE <= 1'h0;
        RX_DATA <= ~p;
        @(posedge MCLK);
    endtask
    task automatic up;
        while ((HOST_FULL_N & RX_FULL_N) !== 1'h1)
            @(posedge MCLK);
        RX_MAIL_SEL <= 1'h0;
        @(posedge MCLK);
    endtask
    task automatic mrst(input logic be, b, input logic [1:0] p);
        apb(1'h1, 8'h00, {30'h0, p}, rd);
        BIG_ENDIAN_SEL <= be;
        FALL_THROUGH_MODE <= be;
        TX_PORT_WIDTH_SEL <= b;
        RX_PORT_WIDTH_SEL <= b;
        RX_MAIL_SEL <= 1'h1;
        FIFO_A2B_MASTER_RESET_N <= 1'h0;
        FIFO_C2A_MASTER_RESET_N <= 1'h0;
        repeat (4) @(posedge MCLK);
        FIFO_A2B_MASTER_RESET_N <= 1'h1;
        FIFO_C2A_MASTER_RESET_N <= 1'h1;
        repeat (4) @(posedge MCLK);
    endtask
    task automatic rdall(input logic [35:0] w, input logic be, b);
        for (int i = 0; i < (b ? 4 : 2); i++)
            txr(pc(w, be ? (b ? 3 : 1) - i : i, b), b);
    endtask
    task automatic wrall(input logic [35:0] w, input logic be, b);
        for (int i = 0; i < (b ? 4 : 2); i++)
            rxp(pc(w, be ? (b ? 3 : 1) - i : i, b) | (b ? 18'h2AA00 : 18'h0));
        while (fifo_arrays_i.got.size() == 0)
            @(posedge MCLK);
        chk("rx", fifo_arrays_i.got.pop_front(), w);
    endtask
    task automatic s_path(input logic be, b);
        logic [35:0] w;
        w = 36'h9A5C31E7B ^ {be, b, 34'h0};
        mrst(be, b, 2'h0);
        up();
        apb(1'h0, 8'h04, 32'h0, rd);
        chk("status", rd[3:0], {b, b, be, be});
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h0, 8'h08 + 8'(4 * i), 32'h0, rd);
            chk("preset", rd, 36'h8);
        end
        apb(1'h0, 8'h40, 32'h0, rd);
        chk("unmapped", {er, rd}, 36'h100000000);
        hw(w);
        rdall(w, be, b);
        wrall(~w, be, b);
    endtask
    task automatic s_ser;
        logic [19:0] v;
        v = {5'h09, 5'h0A, 5'h0B, 5'h0C};
        mrst(1'h0, 1'h1, 2'h3);
        // one strobe per bit, idle cycle between bits
        for (int j = 19; j >= 0; j--)
        begin
            SERIAL_OFFSET_IN <= v[j];
            SERIAL_OFFSET_EN <= 1'h1;
            @(posedge MCLK);
            SERIAL_OFFSET_EN <= 1'h0;
            @(posedge MCLK);
        end
        up();
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h0, 8'h08 + 8'(4 * i), 32'h0, rd);
            chk("serial", rd, 36'(i + 9));
        end
    endtask
    task automatic s_prog;
        logic [35:0] w;
        w = 36'h50F0F1234;
        mrst(1'h1, 1'h0, 2'h1);
        // Offset writes with idle gaps between them
        for (int i = 0; i < 4; i++)
        begin
            HOST_CHIP_SEL_N <= 1'h0;
            HOST_WRITE <= 1'h1;
            HOST_DATA <= 36'(i + 3);
            @(posedge MCLK);
            HOST_CHIP_SEL_N <= 1'h1;
            HOST_WRITE <= 1'h0;
            repeat (2) @(posedge MCLK);
        end
        up();
        chk("held", {35'h0, TX_EMPTY_N}, 36'h0);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h0, 8'h08 + 8'(4 * i), 32'h0, rd);
            chk("offset", rd, 36'(i + 3));
        end
        hw(w);
        txr(pc(w, 1, 1'h0), 1'h0);
        rxp(pc(w, 1, 1'h0));
        // masters stay high in partial reset
        FIFO_A2B_PARTIAL_RESET_N <= 1'h0;
        FIFO_C2A_PARTIAL_RESET_N <= 1'h0;
        repeat (4) @(posedge MCLK);
        FIFO_A2B_PARTIAL_RESET_N <= 1'h1;
        FIFO_C2A_PARTIAL_RESET_N <= 1'h1;
        repeat (3) @(posedge MCLK);
        // fall-through: flag drops one edge after release
        chk("empty hold", {35'h0, TX_EMPTY_N}, 36'h1);
        @(posedge MCLK);
        chk("empty low", {35'h0, TX_EMPTY_N}, 36'h0);
        up();
        hw(~w);
        rdall(~w, 1'h1, 1'h0);
        wrall(w, 1'h1, 1'h0);
    endtask
    // Main sequence
    initial
    begin
        repeat (10) @(posedge MCLK);
        RST <= 1'h0;
        @(posedge MCLK);
        s_path(1'h1, 1'h0);
        s_path(1'h0, 1'h0);
        s_path(1'h1, 1'h1);
        s_path(1'h0, 1'h1);
        s_ser();
        s_prog();
        tally_and_finish();
    end
endmodule // bus_matching_port_adapter_tb
bind bus_matching_port_adapter bmpa_props bmpa_props_i (.*);
`default_nettype wire
